/* core/dac_special_function_decoder.sv */
// Serial word receiver and special-function command decoder
// Functional notes
// - Mode bits 00 make the word a special-function command.
// - Six bits under the mode bits are function code; low sixteen are operand.
// - Code 000001 loads control: bit2 B input, bit1 thermal off, bit0 power-down.
// - Control bit 2 steers channel input writes to B when set, else A.
// - Code 000010 loads operand bits 13..0 into offset DAC zero data.
// - Code 000011 loads operand bits 13..0 into offset DAC one data.
// - Codes 000110..001010 load operand bits 7..0 into bank select 0..4.
// - Code 001011 writes all five bank select registers from operand bits 7..0.
// - Block write operand zero clears all bits, operand one sets all bits.
// - Code 000101 latches the operand as readback selector.
// - Selector bits 15..13 pick channel register type; bits 12..7 channel address.
// - Type 100 selects global register: 1 control, 2-3 offsets, 6-10 bank selects.
// - Code zero with zero operand changes nothing.
// - Selected data leaves on serial out in next frame; driven until sent.
module dac_special_function_decoder
  import sfd_pkg::*;
(
  input wire logic clk_sys,             // System clock, 200 MHz
  input wire logic rst,                 // Async reset, high
  input wire logic sclk,                // Serial clock pin
  input wire logic syncN,               // Frame select pin, low active
  input wire logic sdi,                 // Serial data in pin
  output logic serialDataOut,           // Serial data out level
  output logic serialDataOutOe,         // Serial data out drive enable
  output logic [2:0] controlSettings,   // Control register
  output logic [13:0] offsetDacZeroData, // Offset DAC zero
  output logic [13:0] offsetDacOneData, // Offset DAC one
  output logic [39:0] outputBankSelect, // Bank selects 0..4, 8 bits each
  output logic chanWrValid,             // Channel write pulse
  output logic [1:0] chanWrReg,         // Channel register mode bits
  output logic chanWrToB,               // Input write goes to B
  output logic [5:0] chanWrAddr,        // Channel address bits
  output logic [15:0] chanWrData,       // Channel data
  output logic chanRdReq,               // Channel readback request pulse
  output logic [1:0] chanRdType,        // Channel readback register type
  output logic [5:0] chanRdAddr,        // Channel readback address
  input wire logic [15:0] chanRdData    // Channel readback data
);
  // ==========================================================
  // Pin sampling
  link_if lk ();

  link_sampler u_sampler (
    .clk_sys (clk_sys),
    .rst (rst),
    .sclk (sclk),
    .syncN (syncN),
    .sdi (sdi),
    .lk (lk)
  );

  // ==========================================================
  // Global register readback: bit 16 valid, 15..0 data
  function automatic logic [16:0] globalRead(input logic [5:0] sel, input logic [2:0] ctrl,
      input logic [13:0] offset_dac_zero_data, input logic [13:0] offset_dac_one_data, input logic [4:0][7:0] abs);
    logic [2:0] idx;
    idx = 3'(sel - GS_ABS0);
    globalRead = 17'h00000;
    if (sel == GS_CTRL) begin
      globalRead = {1'b1, 13'h0000, ctrl};
    end else if (sel == GS_OFFSET_DAC_ZERO_DATA) begin
      globalRead = {1'b1, 2'h0, offset_dac_zero_data};
    end else if (sel == GS_OFFSET_DAC_ONE_DATA) begin
      globalRead = {1'b1, 2'h0, offset_dac_one_data};
    end else if (sel >= GS_ABS0 && sel <= GS_ABS4) begin
      globalRead = {1'b1, 8'h00, abs[idx]};
    end
  endfunction

  // ==========================================================
  // Frame receiver
  frame_state_type frame_q, frame_d;
  logic [4:0] bitCnt_q, bitCnt_d;
  logic [23:0] shiftIn_q, shiftIn_d;

  // Shift on falling serial clock; 25th edge spoils the word
  always_comb begin
    frame_d = frame_q;
    bitCnt_d = bitCnt_q;
    shiftIn_d = shiftIn_q;
    case (frame_q)
      FR_IDLE: begin
        if (lk.frameStart) begin
          frame_d = FR_SHIFT;
          bitCnt_d = 5'h00;
        end
      end
      FR_SHIFT: begin
        if (lk.frameEnd) begin
          frame_d = FR_IDLE;
        end else if (lk.sclkFall) begin
          shiftIn_d = {shiftIn_q[22:0], lk.sdiBit};
          bitCnt_d = bitCnt_q + 5'h01;
          if (bitCnt_q == WORD_LAST) begin
            frame_d = FR_FULL;
          end
        end
      end
      FR_FULL: begin
        if (lk.frameEnd) begin
          frame_d = FR_IDLE;
        end else if (lk.sclkFall) begin
          frame_d = FR_OVER;
        end
      end
      FR_OVER: begin
        if (lk.frameEnd) begin
          frame_d = FR_IDLE;
        end
      end
      default: begin
        frame_d = FR_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_q <= FR_IDLE;
      bitCnt_q <= 5'h00;
      shiftIn_q <= 24'h000000;
    end else begin
      frame_q <= frame_d;
      bitCnt_q <= bitCnt_d;
      shiftIn_q <= shiftIn_d;
    end
  end

  // ==========================================================
  // Word fields
  logic execNow, special;
  logic [1:0] mode;
  logic [5:0] func;
  logic [15:0] oper;
  logic [2:0] rbType;
  logic [5:0] rbSel;
  logic [16:0] selRead;

  // Complete word at frame select rise
  assign execNow = (frame_q == FR_FULL) && lk.frameEnd;
  assign mode = shiftIn_q[MODE_HI:MODE_LO];
  assign special = (mode == MODE_SPECIAL);
  assign func = shiftIn_q[FUNC_HI:FUNC_LO];
  assign oper = shiftIn_q[OPER_HI:0];
  assign rbType = oper[RBT_HI:RBT_LO];
  assign rbSel = oper[RBS_HI:RBS_LO];

  // ==========================================================
  // Register bank and channel writes
  logic [2:0] ctrl_q, ctrl_d;
  logic [13:0] offset_dac_zero_data_q, offset_dac_zero_data_d, offset_dac_one_data_q, offset_dac_one_data_d;
  logic [4:0][7:0] abs_q, abs_d;
  logic cwValid_q, cwValid_d, cwToB_q, cwToB_d;
  logic [1:0] cwReg_q, cwReg_d;
  logic [5:0] cwAddr_q, cwAddr_d;
  logic [15:0] cwData_q, cwData_d;

  // Global register picked by the selector in the current word
  assign selRead = globalRead(rbSel, ctrl_q, offset_dac_zero_data_q, offset_dac_one_data_q, abs_q);

  // Execute one completed word
  always_comb begin
    ctrl_d = ctrl_q;
    offset_dac_zero_data_d = offset_dac_zero_data_q;
    offset_dac_one_data_d = offset_dac_one_data_q;
    abs_d = abs_q;
    cwValid_d = 1'b0;
    cwToB_d = cwToB_q;
    cwReg_d = cwReg_q;
    cwAddr_d = cwAddr_q;
    cwData_d = cwData_q;
    if (execNow && !special) begin
      cwValid_d = 1'b1;
      cwReg_d = mode;
      cwAddr_d = shiftIn_q[ADDR_HI:ADDR_LO];
      cwData_d = oper;
      cwToB_d = (mode == MODE_INPUT) && ctrl_q[CTRL_SEL_B];
    end else if (execNow) begin
      // No-op, reserved and undefined codes fall through untouched
      if (func == FN_CTRL) begin
        ctrl_d = oper[2:0];
      end else if (func == FN_OFFSET_DAC_ZERO_DATA) begin
        offset_dac_zero_data_d = oper[OFS_HI:0];
      end else if (func == FN_OFFSET_DAC_ONE_DATA) begin
        offset_dac_one_data_d = oper[OFS_HI:0];
      end else if (func >= FN_ABS0 && func <= FN_ABS4) begin
        abs_d[3'(func - FN_ABS0)] = oper[ABS_HI:0];
      end else if (func == FN_ABSALL) begin
        for (int i = 0; i < 5; i++) begin
          abs_d[i] = (oper[ABS_HI:0] == ABS_ALL_ONES) ? 8'hff : oper[ABS_HI:0];
        end
      end
    end
  end

  // Registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      offset_dac_zero_data_q <= OFS_RESET;
      offset_dac_one_data_q <= OFS_RESET;
      abs_q <= {5{ABS_RESET}};
      cwValid_q <= 1'b0;
      cwToB_q <= 1'b0;
      cwReg_q <= 2'h0;
      cwAddr_q <= 6'h00;
      cwData_q <= 16'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      offset_dac_zero_data_q <= offset_dac_zero_data_d;
      offset_dac_one_data_q <= offset_dac_one_data_d;
      abs_q <= abs_d;
      cwValid_q <= cwValid_d;
      cwToB_q <= cwToB_d;
      cwReg_q <= cwReg_d;
      cwAddr_q <= cwAddr_d;
      cwData_q <= cwData_d;
    end
  end

  // ==========================================================
  // Readback selection and serial data out
  logic rdOk, rdArmed_q, rdArmed_d, rdChan_q, rdChan_d, rdBusy_q, rdBusy_d;
  logic [15:0] rdSel_q, rdSel_d;
  logic [23:0] rdShift_q, rdShift_d;
  logic [4:0] rdCnt_q, rdCnt_d;
  logic sdo_q, sdo_d, sdoOe_q, sdoOe_d, crReq_q, crReq_d;

  // Valid selector: channel type or known global register
  assign rdOk = execNow && special && (func == FN_RDSEL) &&
      (rbType < RB_GLOBAL || (rbType == RB_GLOBAL && selRead[16]));

  // Load at next frame start, shift after each falling edge
  always_comb begin
    rdArmed_d = rdArmed_q;
    rdChan_d = rdChan_q;
    rdBusy_d = rdBusy_q;
    rdSel_d = rdSel_q;
    rdShift_d = rdShift_q;
    rdCnt_d = rdCnt_q;
    sdo_d = sdo_q;
    sdoOe_d = sdoOe_q;
    crReq_d = 1'b0;
    if (lk.frameStart && rdArmed_q) begin
      rdShift_d = rdChan_q ? {8'h00, chanRdData}
          : {8'h00, globalRead(rdSel_q[RBS_HI:RBS_LO], ctrl_q, offset_dac_zero_data_q, offset_dac_one_data_q, abs_q)
            [OPER_HI:0]};
      sdo_d = rdShift_d[23];
      rdCnt_d = 5'h00;
      rdBusy_d = 1'b1;
    end
    if (rdBusy_q && lk.sclkFall && rdCnt_q != WORD_DONE) begin
      rdShift_d = {rdShift_q[22:0], 1'b0};
      sdo_d = rdShift_q[22];
      rdCnt_d = rdCnt_q + 5'h01;
    end
    if (rdBusy_q && lk.frameEnd) begin
      rdBusy_d = 1'b0;
      if (rdCnt_q == WORD_DONE) begin
        rdArmed_d = 1'b0;
        sdoOe_d = 1'b0;
        sdo_d = 1'b0;
      end
    end
    if (rdOk) begin
      rdSel_d = oper;
      rdChan_d = (rbType < RB_GLOBAL);
      rdArmed_d = 1'b1;
      sdoOe_d = 1'b1;
      crReq_d = (rbType < RB_GLOBAL);
    end
  end

  // Registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdArmed_q <= 1'b0;
      rdChan_q <= 1'b0;
      rdBusy_q <= 1'b0;
      rdSel_q <= 16'h0000;
      rdShift_q <= 24'h000000;
      rdCnt_q <= 5'h00;
      sdo_q <= 1'b0;
      sdoOe_q <= 1'b0;
      crReq_q <= 1'b0;
    end else begin
      rdArmed_q <= rdArmed_d;
      rdChan_q <= rdChan_d;
      rdBusy_q <= rdBusy_d;
      rdSel_q <= rdSel_d;
      rdShift_q <= rdShift_d;
      rdCnt_q <= rdCnt_d;
      sdo_q <= sdo_d;
      sdoOe_q <= sdoOe_d;
      crReq_q <= crReq_d;
    end
  end

  // ==========================================================
  // Outputs
  assign serialDataOut = sdo_q;
  assign serialDataOutOe = sdoOe_q;
  assign controlSettings = ctrl_q;
  assign offsetDacZeroData = offset_dac_zero_data_q;
  assign offsetDacOneData = offset_dac_one_data_q;
  assign outputBankSelect = abs_q;
  assign chanWrValid = cwValid_q;
  assign chanWrReg = cwReg_q;
  assign chanWrToB = cwToB_q;
  assign chanWrAddr = cwAddr_q;
  assign chanWrData = cwData_q;
  assign chanRdReq = crReq_q;
  assign chanRdType = rdSel_q[14:13];
  assign chanRdAddr = rdSel_q[RBS_HI:RBS_LO];

  // ==========================================================
  // Assertions
  property p_mode_special;
    @(posedge clk_sys) disable iff (rst)
      execNow && !special |=> chanWrValid && chanWrReg == $past(mode);
  endproperty
  a_mode_special: assert property (p_mode_special) else $error("channel write missing");

  property p_ctrl_write;
    @(posedge clk_sys) disable iff (rst)
      execNow && special && func == FN_CTRL |=> controlSettings == $past(oper[2:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control not loaded");

  property p_steer_b;
    @(posedge clk_sys) disable iff (rst)
      execNow && mode == MODE_INPUT |=> chanWrToB == controlSettings[CTRL_SEL_B];
  endproperty
  a_steer_b: assert property (p_steer_b) else $error("input bank steering wrong");

  property p_offset_dac_zero_data;
    @(posedge clk_sys) disable iff (rst)
      execNow && special && func == FN_OFFSET_DAC_ZERO_DATA |=>
        offsetDacZeroData == $past(oper[13:0]) && $stable(offsetDacOneData);
  endproperty
  a_offset_dac_zero_data: assert property (p_offset_dac_zero_data) else $error("offset zero not loaded");

  property p_offset_dac_one_data;
    @(posedge clk_sys) disable iff (rst)
      execNow && special && func == FN_OFFSET_DAC_ONE_DATA |=>
        offsetDacOneData == $past(oper[13:0]) && $stable(offsetDacZeroData);
  endproperty
  a_offset_dac_one_data: assert property (p_offset_dac_one_data) else $error("offset one not loaded");

  property p_abs_one;
    @(posedge clk_sys) disable iff (rst)
      execNow && special && func == FN_ABS4 |=>
        outputBankSelect[39:32] == $past(oper[7:0]) && $stable(outputBankSelect[31:0]);
  endproperty
  a_abs_one: assert property (p_abs_one) else $error("bank select four wrong");

  property p_abs_all;
    @(posedge clk_sys) disable iff (rst)
      execNow && special && func == FN_ABSALL && oper[7:0] == 8'h01 |=> outputBankSelect == {40{1'b1}};
  endproperty
  a_abs_all: assert property (p_abs_all) else $error("block write of ones failed");

  property p_nop;
    @(posedge clk_sys) disable iff (rst)
      execNow && special && func == FN_NOP |=>
        $stable(controlSettings) && $stable(outputBankSelect) && !chanWrValid;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");

  property p_only_at_end;
    @(posedge clk_sys) disable iff (rst) $changed(controlSettings) |-> $past(execNow);
  endproperty
  a_only_at_end: assert property (p_only_at_end) else $error("control changed early");

  property p_oe_cause;
    @(posedge clk_sys) disable iff (rst) $rose(serialDataOutOe) |-> $past(rdOk);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("serial out driven without read");

  property p_chan_req;
    @(posedge clk_sys) disable iff (rst)
      rdOk && rbType < RB_GLOBAL |=> chanRdReq && chanRdAddr == $past(rbSel);
  endproperty
  a_chan_req: assert property (p_chan_req) else $error("channel request wrong");

  c_ctrl: cover property (@(posedge clk_sys) disable iff (rst) execNow && special && func == FN_CTRL);
  c_read: cover property (@(posedge clk_sys) disable iff (rst) $fell(serialDataOutOe));
  c_abort: cover property (@(posedge clk_sys) disable iff (rst) frame_q == FR_SHIFT && lk.frameEnd);
  c_chan: cover property (@(posedge clk_sys) disable iff (rst) chanWrValid);
endmodule // dac_special_function_decoder

/* core/link_sampler.sv */
// Pin synchroniser and edge finder for the serial link
module link_sampler
  import sfd_pkg::*;
(
  input wire logic clk_sys,   // System clock
  input wire logic rst,       // Async reset, high
  input wire logic sclk,      // Serial clock pin
  input wire logic syncN,     // Frame select pin, low active
  input wire logic sdi,       // Serial data pin
  link_if.front lk            // Sampled events
);
  // ==========================================================
  // Three-stage sampling, bit 0 sclk, 1 syncN, 2 sdi
  logic [2:0] st0_q, st1_q, st2_q, lvl_q, lvl_d;
  logic fall_q, fall_d, fs_q, fs_d, fe_q, fe_d, bit_q, bit_d;

  // Level accepted once stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < 3; i++) begin
      if (st1_q[i] == st2_q[i]) begin
        lvl_d[i] = st2_q[i];
      end
    end
    fall_d = lvl_q[0] & ~lvl_d[0];
    fs_d = lvl_q[1] & ~lvl_d[1];
    fe_d = ~lvl_q[1] & lvl_d[1];
    bit_d = lvl_d[2];
  end

  // Registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st0_q <= 3'h2;
      st1_q <= 3'h2;
      st2_q <= 3'h2;
      lvl_q <= 3'h2;
      fall_q <= 1'b0;
      fs_q <= 1'b0;
      fe_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      st0_q <= {sdi, syncN, sclk};
      st1_q <= st0_q;
      st2_q <= st1_q;
      lvl_q <= lvl_d;
      fall_q <= fall_d;
      fs_q <= fs_d;
      fe_q <= fe_d;
      bit_q <= bit_d;
    end
  end

  assign lk.sclkFall = fall_q;
  assign lk.frameStart = fs_q;
  assign lk.frameEnd = fe_q;
  assign lk.sdiBit = bit_q;
endmodule // link_sampler

/* include/link_if.sv */
// Sampled link events passed from the pin sampler to the decoder
interface link_if;
  logic sclkFall;
  logic frameStart;
  logic frameEnd;
  logic sdiBit;
  modport front (output sclkFall, output frameStart, output frameEnd, output sdiBit);
  modport core (input sclkFall, input frameStart, input frameEnd, input sdiBit);
endinterface

/* include/sfd_pkg.sv */
// Constants and types for the special-function decoder
package sfd_pkg;
  // ==========================================================
  // Serial word layout
  localparam logic [4:0] WORD_LAST = 5'h17;
  localparam logic [4:0] WORD_DONE = 5'h18;
  localparam int MODE_HI = 23;
  localparam int MODE_LO = 22;
  localparam int FUNC_HI = 21;
  localparam int FUNC_LO = 16;
  localparam int ADDR_HI = 21;
  localparam int ADDR_LO = 16;
  localparam int OPER_HI = 15;
  localparam int OFS_HI = 13;
  localparam int ABS_HI = 7;
  localparam int RBT_HI = 15;
  localparam int RBT_LO = 13;
  localparam int RBS_HI = 12;
  localparam int RBS_LO = 7;
  // ==========================================================
  // Mode bits
  localparam logic [1:0] MODE_SPECIAL = 2'h0;
  localparam logic [1:0] MODE_INPUT = 2'h3;
  // ==========================================================
  // Function codes
  localparam logic [5:0] FN_NOP = 6'h00;
  localparam logic [5:0] FN_CTRL = 6'h01;
  localparam logic [5:0] FN_OFFSET_DAC_ZERO_DATA = 6'h02;
  localparam logic [5:0] FN_OFFSET_DAC_ONE_DATA = 6'h03;
  localparam logic [5:0] FN_RDSEL = 6'h05;
  localparam logic [5:0] FN_ABS0 = 6'h06;
  localparam logic [5:0] FN_ABS4 = 6'h0a;
  localparam logic [5:0] FN_ABSALL = 6'h0b;
  localparam logic [7:0] ABS_ALL_ONES = 8'h01;
  // ==========================================================
  // Control bit positions
  localparam int CTRL_SEL_B = 2;
  localparam int CTRL_THERM = 1;
  localparam int CTRL_PDOWN = 0;
  // ==========================================================
  // Readback selector codes
  localparam logic [2:0] RB_GLOBAL = 3'h4;
  localparam logic [5:0] GS_CTRL = 6'h01;
  localparam logic [5:0] GS_OFFSET_DAC_ZERO_DATA = 6'h02;
  localparam logic [5:0] GS_OFFSET_DAC_ONE_DATA = 6'h03;
  localparam logic [5:0] GS_ABS0 = 6'h06;
  localparam logic [5:0] GS_ABS4 = 6'h0a;
  // ==========================================================
  // Reset values
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [13:0] OFS_RESET = 14'h0000;
  localparam logic [7:0] ABS_RESET = 8'h00;
  // ==========================================================
  // Frame receiver states
  typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_FULL, FR_OVER} frame_state_type;
endpackage

/* testbench/dac_special_function_decoder_tb.sv */
// Self-checking bench for the special-function decoder
`define CHK(what, exp, got) \
  begin \
    nCompared++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module dac_special_function_decoder_tb
  import sfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst, sclk, syncN, sdi, serialDataOut, serialDataOutOe;
  logic [2:0] controlSettings;
  logic [13:0] offsetDacZeroData, offsetDacOneData;
  logic [39:0] outputBankSelect;
  logic chanWrValid, chanWrToB, chanRdReq;
  logic [1:0] chanWrReg, chanRdType;
  logic [5:0] chanWrAddr, chanRdAddr;
  logic [15:0] chanWrData, chanRdData;
  int errors = 0;
  int nCompared = 0;
  int wrPulses = 0;
  int rdPulses = 0;
  // ==========================================================
  // Device and host
  dac_special_function_decoder i_dut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk),
    .syncN(syncN), .sdi(sdi), .serialDataOut(serialDataOut),
    .serialDataOutOe(serialDataOutOe), .controlSettings(controlSettings),
    .offsetDacZeroData(offsetDacZeroData), .offsetDacOneData(offsetDacOneData),
    .outputBankSelect(outputBankSelect), .chanWrValid(chanWrValid),
    .chanWrReg(chanWrReg), .chanWrToB(chanWrToB), .chanWrAddr(chanWrAddr),
    .chanWrData(chanWrData), .chanRdReq(chanRdReq), .chanRdType(chanRdType),
    .chanRdAddr(chanRdAddr), .chanRdData(chanRdData));
  host_link_model i_host (.sclk(sclk), .syncN(syncN), .sdi(sdi),
    .serialDataOut(serialDataOut), .serialDataOutOe(serialDataOutOe));
  // ==========================================================
  // Clock and pulse counters
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (chanWrValid === 1'b1) wrPulses <= wrPulses + 1;
    if (chanRdReq === 1'b1) rdPulses <= rdPulses + 1;
  end
  // ==========================================================
  // Access tasks
  function automatic logic [23:0] sf(input logic [5:0] fn, input logic [15:0] op);
    return {MODE_SPECIAL, fn, op};
  endfunction
  function automatic logic [15:0] gsel(input logic [5:0] g);
    return {RB_GLOBAL, g, 7'h00};
  endfunction
  task automatic wr(input logic [23:0] w);
    logic [23:0] junk;
    i_host.frame(w, 24, junk);
  endtask
  // Select a register, then collect it with a no-op frame
  task automatic rdBack(input logic [15:0] sel, output logic [23:0] got);
    wr(sf(FN_RDSEL, sel));
    `CHK("oe armed", 1'b1, serialDataOutOe)
    i_host.frame(24'h000000, 24, got);
    `CHK("oe released", 1'b0, serialDataOutOe)
  endtask
  task automatic chkAll(input logic [70:0] exp);
    `CHK("regs", exp, {controlSettings, offsetDacZeroData, offsetDacOneData,
      outputBankSelect})
  endtask
  task automatic finish_test();
    if (errors == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #400000;
    errors++;
    finish_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [23:0] got;
    logic [39:0] banks;
    logic [23:0] ign [4];
    int n0;
    rst = 1'b1;
    chanRdData = 16'hc3a5;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    repeat (8) @(negedge clk_sys);
    chkAll(71'h0);
    wr(sf(FN_CTRL, 16'hfffd));
    `CHK("control", 3'h5, controlSettings)
    rdBack(gsel(GS_CTRL), got);
    `CHK("ctrl rb", 24'h000005, got)
    wr(sf(FN_OFFSET_DAC_ZERO_DATA, 16'hffff));
    wr(sf(FN_OFFSET_DAC_ONE_DATA, 16'h8123));
    `CHK("offset_dac_zero_data", 14'h3fff, offsetDacZeroData)
    `CHK("offset_dac_one_data", 14'h0123, offsetDacOneData)
    rdBack(gsel(GS_OFFSET_DAC_ONE_DATA), got);
    `CHK("offset_dac_one_data rb", 24'h000123, got)
    for (int i = 0; i < 5; i++) begin
      banks[i*8 +: 8] = 8'h11 * 8'(i + 1);
      wr(sf(FN_ABS0 + 6'(i), {8'ha5, banks[i*8 +: 8]}));
    end
    `CHK("banks", banks, outputBankSelect)
    for (int i = 0; i < 5; i++) begin
      rdBack(gsel(GS_ABS0 + 6'(i)), got);
      `CHK("bank rb", {16'h0000, banks[i*8 +: 8]}, got)
    end
    wr(sf(FN_ABSALL, 16'hff01));
    `CHK("block ones", {40{1'b1}}, outputBankSelect)
    wr(sf(FN_ABSALL, 16'h005a));
    `CHK("block", {5{8'h5a}}, outputBankSelect)
    wr(sf(FN_ABSALL, 16'h0000));
    `CHK("block zero", 40'h0, outputBankSelect)
    wr(sf(FN_ABSALL, 16'h0033));
    ign = '{sf(FN_NOP, 16'h0000), sf(6'h04, 16'h1234), sf(6'h3f, 16'hffff),
      sf(FN_NOP, 16'h0001)};
    foreach (ign[k]) begin
      wr(ign[k]);
      chkAll({3'h5, 14'h3fff, 14'h0123, {5{8'h33}}});
    end
    i_host.frame(sf(FN_CTRL, 16'h0000), 23, got);
    `CHK("abort", 3'h5, controlSettings)
    wr(sf(FN_RDSEL, gsel(6'h04)));
    `CHK("reserved sel", 1'b0, serialDataOutOe)
    `CHK("no wr pulse", 0, wrPulses)
    wr({MODE_INPUT, 6'h05, 16'hbeef});
    `CHK("wr pulse", 1, wrPulses)
    `CHK("wr word", {2'h3, 6'h05, 16'hbeef}, {chanWrReg, chanWrAddr, chanWrData})
    `CHK("to B", 1'b1, chanWrToB)
    wr(sf(FN_CTRL, 16'h0001));
    wr({MODE_INPUT, 6'h07, 16'h1234});
    `CHK("to A", 1'b0, chanWrToB)
    wr({2'h2, 6'h07, 16'h1234});
    `CHK("offset reg", 2'h2, chanWrReg)
    for (int t = 0; t < 4; t++) begin
      n0 = rdPulses;
      rdBack({1'b0, 2'(t), 6'h09, 7'h00}, got);
      `CHK("rd pulse", n0 + 1, rdPulses)
      `CHK("rd sel", {2'(t), 6'h09}, {chanRdType, chanRdAddr})
      `CHK("chan rb", 24'h00c3a5, got)
    end
    finish_test();
  end
endmodule // dac_special_function_decoder_tb

/* testbench/host_link_model.sv */
// Host side of the serial link: frames words and collects readback
module host_link_model (
  output logic sclk,               // Serial clock, idles high
  output logic syncN,              // Frame select, low active
  output logic sdi,                // Serial data to device
  input wire logic serialDataOut,  // Device data out level
  input wire logic serialDataOutOe // Device data out enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastBit;
  // Idle pins; clock stands still between frames
  initial begin
    sclk = 1'b1;
    syncN = 1'b1;
    sdi = 1'b0;
    lastBit = 1'b0;
  end
  // Undriven line shows the inverse of its last value
  function automatic logic seen();
    return serialDataOutOe ? serialDataOut : ~lastBit;
  endfunction
  // One frame of n falls; fewer than 24 aborts the word
  task automatic frame(input logic [23:0] w, input int n, output logic [23:0] rd);
    rd = '0;
    syncN = 1'b0;
    #32;
    for (int i = 0; i < n; i++) begin
      sdi = w[23-i];
      #32;
      lastBit = seen();
      rd = {rd[22:0], lastBit};
      sclk = 1'b0;
      #32;
      sclk = 1'b1;
    end
    #32;
    syncN = 1'b1;
    sdi = ~sdi;
    #150;
  endtask
endmodule // host_link_model
